// *** rtl/psm_pkg.sv ***
// Purpose: Shared constants for the power-saving mode controller.
// Assumes: Avalon-MM register access with 32-bit data and word addressing by byte address.
// Notes:   The power control register is kept at its special-function index.
package psm_pkg;

  // Special-function index of the power control register; byte address is four times it.
  localparam logic [7:0]  PWR_CTRL_INDEX = 8'h87;
  localparam logic [9:0]  PWR_CTRL_ADDR  = {PWR_CTRL_INDEX, 2'b00};
  // Byte address of the status register that shows the block's own state.
  localparam logic [9:0]  PWR_STAT_ADDR  = 10'h220;

  // Field positions inside the power control register.
  localparam int BIT_IDLE   = 0;
  localparam int BIT_STOP   = 1;
  localparam int BIT_FLAG0  = 2;
  localparam int BIT_FLAG1  = 3;
  localparam int BIT_DOUBLE = 7;

  // Reset value and writable-bit mask of the power control register.
  localparam logic [7:0]  PWR_CTRL_RESET = 8'h00;
  localparam logic [7:0]  PWR_CTRL_MASK  = 8'h8F;

  // Clock rate and the least hold of a reset that ends Idle, in instruction cycles.
  localparam int CLOCK_MHZ        = 200;
  localparam int CLKS_PER_INSTR   = 12;
  localparam int IDLE_RESET_INSTR = 2;
  localparam int IDLE_RESET_CLKS  = IDLE_RESET_INSTR * CLKS_PER_INSTR;

  // Operating modes, one-hot.
  typedef enum logic [2:0] {
    MODE_RUN  = 3'b001,
    MODE_IDLE = 3'b010,
    MODE_STOP = 3'b100
  } psm_mode_e;

endpackage : psm_pkg

// *** rtl/psm_power_ctrl.sv ***
// Purpose: Power-saving mode controller: Idle and Stop entry, wake-up and pin states.
// Assumes: Resets arrive already synchronous to i_clock; interrupt inputs are on i_clock.
// Notes:   Core clock gating is an enable here; the clock tree uses it as a latch enable.
//
// What this block does
// - Power control register at index 87h, idle bit0, stop bit1.
// - Writing idle bit enters Idle mode.
// - Writing stop bit enters Stop mode.
// - Both bits set: Stop wins over Idle.
// - Idle halts CPU; peripherals keep running.
// - Setting instruction is last before Idle.
// - Idle keeps all CPU state unchanged.
// - Enabled interrupt clears idle bit, unless blocked by priority.
// - Interrupt serviced, then execution resumes after setter.
// - Bits 3 and 2 are free software flags.
// - Bit 7 doubles baud rate; bits 6-4 reserved.
// - Watchdog reset also ends Idle.
// - Stop halts oscillator and preserves memories.
// - Stop refused while watchdog is enabled.
// - Only external reset ends Stop; clears registers.
// - Idle drives strobes high; port 0 floats externally.
// - Stop drives strobes low; port 0 floats externally.
//
// The Avalon-MM interface to the registers was left to the implementer.

`timescale 1ns/1ps

module psm_power_ctrl (
  input  wire logic        i_clock,
  input  wire logic        i_nrst,
  // Avalon-MM slave.
  input  wire logic [9:0]  i_address,
  input  wire logic        i_read,
  input  wire logic        i_write,
  input  wire logic [31:0] i_writedata,
  output logic      [31:0] o_readdata,
  output logic             o_waitrequest,
  output logic      [1:0]  o_response,
  // Core and system side.
  input  wire logic        i_instr_done,
  input  wire logic        i_irq_wake,
  input  wire logic        i_irq_blocked,
  input  wire logic        i_watchdog_on,
  input  wire logic        i_wdt_reset,
  input  wire logic        i_ext_mem,
  output logic             o_core_clk_en,
  output logic             o_osc_en,
  output logic             o_uart_rate_double,
  output logic             o_addr_latch_strobe,
  output logic             o_prog_store_strobe,
  output logic             o_port0_float,
  output logic             o_port2_addr,
  output logic             o_in_idle,
  output logic             o_in_stop
);

  psm_pkg::psm_mode_e mode;
  psm_pkg::psm_mode_e next_mode;
  logic [7:0]         power_control;
  logic               bus_pending;
  logic [31:0]        next_readdata;
  logic               wr_ctrl;
  logic               hit_ctrl;
  logic               hit_stat;
  logic               wake_irq;
  logic               stop_ok;

  // Decode of the two mapped words.
  assign hit_ctrl = (i_address == psm_pkg::PWR_CTRL_ADDR);
  assign hit_stat = (i_address == psm_pkg::PWR_STAT_ADDR);
  assign wr_ctrl  = i_write && bus_pending && hit_ctrl;
  assign wake_irq = i_irq_wake && !i_irq_blocked;
  assign stop_ok  = !i_watchdog_on;

  // Every access waits one cycle, then completes with waitrequest low.
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      bus_pending <= 1'b0;
    end else if ((i_read || i_write) && !bus_pending) begin
      bus_pending <= 1'b1;
    end else begin
      bus_pending <= 1'b0;
    end
  end

  // Waitrequest stays high until the access is answered.
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      o_waitrequest <= 1'b1;
    end else begin
      o_waitrequest <= !((i_read || i_write) && !bus_pending);
    end
  end

  // Read data mux; unmapped words read zero with a decode-error response.
  always_comb begin
    next_readdata = 32'h0000_0000;
    if (hit_ctrl) begin
      next_readdata = {24'h00_0000, power_control & psm_pkg::PWR_CTRL_MASK};
    end else if (hit_stat) begin
      next_readdata = {29'h0000_0000, mode};
    end
  end

  // Read data and response are captured with the answer.
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      o_readdata <= 32'h0000_0000;
      o_response <= 2'b00;
    end else if ((i_read || i_write) && !bus_pending) begin
      o_readdata <= i_read ? next_readdata : 32'h0000_0000;
      o_response <= (hit_ctrl || hit_stat) ? 2'b00 : 2'b11;
    end
  end

  // Power control register: software write, hardware clears the idle bit on wake.
  always_ff @(posedge i_clock) begin
    // A watchdog reset in Stop must not clear the register that Stop preserves.
    if (!i_nrst || (i_wdt_reset && mode != psm_pkg::MODE_STOP)) begin
      power_control <= psm_pkg::PWR_CTRL_RESET;
    end else if (wr_ctrl) begin
      power_control <= i_writedata[7:0] & psm_pkg::PWR_CTRL_MASK;
      if (!stop_ok) begin
        power_control[psm_pkg::BIT_STOP] <= 1'b0;
      end
    end else if (mode == psm_pkg::MODE_IDLE && wake_irq) begin
      power_control[psm_pkg::BIT_IDLE] <= 1'b0;
    end
  end

  // Mode decision; Stop outranks Idle and only takes effect once the current instruction completes (i_instr_done).
  always_comb begin
    next_mode = mode;
    unique case (mode)
      psm_pkg::MODE_RUN: begin
        if (power_control[psm_pkg::BIT_STOP] && stop_ok && i_instr_done) begin
          next_mode = psm_pkg::MODE_STOP;
        end else if (power_control[psm_pkg::BIT_IDLE] && i_instr_done) begin
          next_mode = psm_pkg::MODE_IDLE;
        end
      end
      psm_pkg::MODE_IDLE: begin
        if (wake_irq) begin
          next_mode = psm_pkg::MODE_RUN;
        end
      end
      psm_pkg::MODE_STOP: begin
        next_mode = psm_pkg::MODE_STOP;
      end
      default: next_mode = psm_pkg::MODE_RUN;
    endcase
  end

  // Mode register; external reset ends any mode, watchdog reset ends Idle.
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      mode <= psm_pkg::MODE_RUN;
    end else if (i_wdt_reset && mode != psm_pkg::MODE_STOP) begin
      mode <= psm_pkg::MODE_RUN;
    end else begin
      mode <= next_mode;
    end
  end

  // Clock enables: Idle freezes only the core, Stop halts the oscillator.
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      o_core_clk_en <= 1'b1;
      o_osc_en      <= 1'b1;
    end else begin
      o_core_clk_en <= (next_mode == psm_pkg::MODE_RUN);
      o_osc_en      <= (next_mode != psm_pkg::MODE_STOP);
    end
  end

  // Pin states and status outputs for each mode.
  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      o_addr_latch_strobe <= 1'b1;
      o_prog_store_strobe <= 1'b1;
      o_port0_float       <= 1'b0;
      o_port2_addr        <= 1'b0;
      o_in_idle           <= 1'b0;
      o_in_stop           <= 1'b0;
      o_uart_rate_double  <= 1'b0;
    end else begin
      o_addr_latch_strobe <= (next_mode != psm_pkg::MODE_STOP);
      o_prog_store_strobe <= (next_mode != psm_pkg::MODE_STOP);
      o_port0_float       <= i_ext_mem && (next_mode != psm_pkg::MODE_RUN);
      o_port2_addr        <= i_ext_mem && (next_mode == psm_pkg::MODE_IDLE);
      o_in_idle           <= (next_mode == psm_pkg::MODE_IDLE);
      o_in_stop           <= (next_mode == psm_pkg::MODE_STOP);
      o_uart_rate_double  <= power_control[psm_pkg::BIT_DOUBLE];
    end
  end

  // Named steps used by the checks below.
  sequence s_idle_armed;
    mode == psm_pkg::MODE_RUN && power_control[psm_pkg::BIT_IDLE]
      && !power_control[psm_pkg::BIT_STOP] && i_instr_done && !i_wdt_reset;
  endsequence

  sequence s_idle_woken;
    mode == psm_pkg::MODE_IDLE && wake_irq && !i_wdt_reset && !wr_ctrl;
  endsequence

  a_idle_entry_core: assert property (@(posedge i_clock) disable iff (!i_nrst)
    s_idle_armed |=> mode == psm_pkg::MODE_IDLE ##0 !o_core_clk_en)
    else $error("Idle not entered after idle request.");

  a_stop_over_idle: assert property (@(posedge i_clock) disable iff (!i_nrst)
    mode == psm_pkg::MODE_RUN && power_control[1:0] == 2'b11 && stop_ok && i_instr_done
      && !i_wdt_reset |=> mode == psm_pkg::MODE_STOP)
    else $error("Stop did not win over Idle.");

  a_stop_osc_off: assert property (@(posedge i_clock) disable iff (!i_nrst)
    mode == psm_pkg::MODE_STOP |-> !o_osc_en && !o_prog_store_strobe)
    else $error("Oscillator or strobes active in Stop.");

  a_stop_refused: assert property (@(posedge i_clock) disable iff (!i_nrst)
    mode == psm_pkg::MODE_RUN && i_watchdog_on |=> mode != psm_pkg::MODE_STOP)
    else $error("Stop entered with watchdog enabled.");

  a_idle_wake_clear: assert property (@(posedge i_clock) disable iff (!i_nrst)
    s_idle_woken |=> mode == psm_pkg::MODE_RUN && !power_control[psm_pkg::BIT_IDLE]
      ##0 o_core_clk_en)
    else $error("Interrupt did not end Idle.");

  a_idle_blocked: assert property (@(posedge i_clock) disable iff (!i_nrst)
    mode == psm_pkg::MODE_IDLE && i_irq_blocked && !i_wdt_reset |=> mode == psm_pkg::MODE_IDLE)
    else $error("Blocked interrupt ended Idle.");

  a_stop_sticks: assert property (@(posedge i_clock) disable iff (!i_nrst)
    mode == psm_pkg::MODE_STOP |=> mode == psm_pkg::MODE_STOP [*2])
    else $error("Stop left without external reset.");

  a_wdt_ends_idle: assert property (@(posedge i_clock) disable iff (!i_nrst)
    mode == psm_pkg::MODE_IDLE && i_wdt_reset |=> mode == psm_pkg::MODE_RUN
      && power_control == psm_pkg::PWR_CTRL_RESET)
    else $error("Watchdog reset did not end Idle.");

  a_idle_pins: assert property (@(posedge i_clock) disable iff (!i_nrst)
    mode == psm_pkg::MODE_IDLE |-> o_addr_latch_strobe && o_prog_store_strobe
      && o_port2_addr == i_ext_mem && $stable(power_control[3:2]))
    else $error("Idle pin state wrong.");

  a_reserved_zero: assert property (@(posedge i_clock) disable iff (!i_nrst)
    power_control[6:4] == 3'b000)
    else $error("Reserved bits not zero.");

endmodule // psm_power_ctrl

// *** tb/psm_core_model.sv ***
// Purpose: Behavioural core and interrupt controller beside the power block.
// Assumes: One clock; every instruction of the core takes three cycles.
// Notes:   Interrupt request and priority hold are commanded by the bench.
`timescale 1ns/1ps
module psm_core_model (
  input  wire logic i_clock,
  input  wire logic i_nrst,
  input  wire logic i_core_clk_en,
  input  wire logic i_irq_req,
  input  wire logic i_irq_hold,
  output logic      o_instr_done,
  output logic      o_irq_wake,
  output logic      o_irq_blocked
);
  logic [1:0] step;
  // Instructions only complete while the core clock runs, so none runs in Idle.
  always_ff @(posedge i_clock) begin
    if (!i_nrst || !i_core_clk_en) step <= 2'h0;
    else step <= (step == 2'h2) ? 2'h0 : step + 2'h1;
  end
  assign o_instr_done  = i_core_clk_en && (step == 2'h2);
  // Interrupt lines are levels held as long as the bench asks.
  assign o_irq_wake    = i_irq_req;
  assign o_irq_blocked = i_irq_hold;
endmodule // psm_core_model

// *** tb/tb.sv ***
// Purpose: Self-checking bench for the power-saving mode controller.
// Assumes: Register access over Avalon-MM; a core model drives the core-side lines.
// Notes:   Expected values come from the register layout in the package.
`timescale 1ns/1ps
module tb;
  logic i_clock = 1'b0, i_nrst = 1'b0, i_read = 1'b0, i_write = 1'b0;
  logic [9:0] i_address = 10'h000;
  logic [31:0] i_writedata = 32'h0, o_readdata, rd;
  logic [1:0] o_response, rs;
  logic o_waitrequest, done, wake, blk, irq_req = 1'b0, irq_hold = 1'b0;
  logic i_watchdog_on = 1'b0, i_wdt_reset = 1'b0, i_ext_mem = 1'b1;
  logic o_core_clk_en, o_osc_en, o_uart_rate_double, o_addr_latch_strobe;
  logic o_prog_store_strobe, o_port0_float, o_port2_addr, o_in_idle, o_in_stop;
  int err_total = 0, num_checks = 0;
  localparam logic [9:0] PC = psm_pkg::PWR_CTRL_ADDR;

  // The clock toggles every half period of 2.5 ns.
  always #2.5 i_clock = ~i_clock;

  psm_power_ctrl dut_u (.i_clock(i_clock), .i_nrst(i_nrst), .i_address(i_address),
    .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata), .o_readdata(o_readdata),
    .o_waitrequest(o_waitrequest), .o_response(o_response), .i_instr_done(done),
    .i_irq_wake(wake), .i_irq_blocked(blk), .i_watchdog_on(i_watchdog_on),
    .i_wdt_reset(i_wdt_reset), .i_ext_mem(i_ext_mem), .o_core_clk_en(o_core_clk_en),
    .o_osc_en(o_osc_en), .o_uart_rate_double(o_uart_rate_double),
    .o_addr_latch_strobe(o_addr_latch_strobe), .o_prog_store_strobe(o_prog_store_strobe),
    .o_port0_float(o_port0_float), .o_port2_addr(o_port2_addr), .o_in_idle(o_in_idle),
    .o_in_stop(o_in_stop));
  psm_core_model core_u (.i_clock(i_clock), .i_nrst(i_nrst), .i_core_clk_en(o_core_clk_en),
    .i_irq_req(irq_req), .i_irq_hold(irq_hold), .o_instr_done(done), .o_irq_wake(wake),
    .o_irq_blocked(blk));

  // Counts a comparison and reports a mismatch at once.
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // Prints the verdict and ends the run.
  task close_out();
    if (err_total == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // One bus access: held until waitrequest is sampled low, then released.
  task bus(input logic wr, input logic [9:0] a, input logic [31:0] d);
    @(posedge i_clock);
    i_address <= a;
    i_writedata <= d;
    i_write <= wr;
    i_read <= !wr;
    do @(posedge i_clock); while (o_waitrequest !== 1'b0);
    rd = o_readdata;
    rs = o_response;
    i_write <= 1'b0;
    i_read <= 1'b0;
  endtask

  task wait_mode(input logic idle, input logic stop);
    do @(posedge i_clock); while ({o_in_idle, o_in_stop} !== {idle, stop});
  endtask

  // Watchdog: cuts a hang short.
  initial begin
    repeat (20000) @(posedge i_clock);
    err_total++;
    close_out();
  end

  // Main sequence of register accesses and mode changes.
  initial begin
    repeat (16) @(posedge i_clock);
    i_nrst <= 1'b1;
    bus(1'b0, PC, 32'h0); chk(rd, 32'h0);
    bus(1'b0, psm_pkg::PWR_STAT_ADDR, 32'h0); chk(rd, 32'(psm_pkg::MODE_RUN));
    bus(1'b1, PC, 32'hFC);
    bus(1'b0, PC, 32'h0); chk(rd, 32'h8C);
    chk(o_uart_rate_double, 1'b1);
    bus(1'b1, 10'h300, 32'hFF); chk(rs, 2'h3);
    bus(1'b0, 10'h300, 32'h0); chk({rs, rd}, {2'h3, 32'h0});
    bus(1'b1, PC, 32'h0D);
    wait_mode(1'b1, 1'b0);
    chk({o_core_clk_en, o_osc_en, o_addr_latch_strobe, o_prog_store_strobe}, 4'h7);
    chk({o_port0_float, o_port2_addr}, 2'h3);
    irq_hold <= 1'b1;
    irq_req <= 1'b1;
    repeat (10) @(posedge i_clock);
    chk(o_in_idle, 1'b1);
    irq_hold <= 1'b0;
    wait_mode(1'b0, 1'b0);
    irq_req <= 1'b0;
    chk(o_core_clk_en, 1'b1);
    bus(1'b0, PC, 32'h0); chk(rd, 32'h0C);
    i_ext_mem <= 1'b0;
    bus(1'b1, PC, 32'h01);
    wait_mode(1'b1, 1'b0);
    chk({o_port0_float, o_port2_addr}, 2'h0);
    i_wdt_reset <= 1'b1;
    @(posedge i_clock);
    i_wdt_reset <= 1'b0;
    wait_mode(1'b0, 1'b0);
    bus(1'b0, PC, 32'h0); chk(rd, 32'h0);
    bus(1'b1, PC, 32'h01);
    wait_mode(1'b1, 1'b0);
    i_nrst <= 1'b0;
    repeat (psm_pkg::IDLE_RESET_CLKS) @(posedge i_clock);
    i_nrst <= 1'b1;
    @(posedge i_clock);
    chk({o_in_idle, o_core_clk_en}, 2'h1);
    bus(1'b0, PC, 32'h0); chk(rd, 32'h0);
    i_ext_mem <= 1'b1;
    i_watchdog_on <= 1'b1;
    bus(1'b1, PC, 32'h02);
    repeat (10) @(posedge i_clock);
    chk(o_in_stop, 1'b0);
    bus(1'b0, PC, 32'h0); chk(rd, 32'h0);
    i_watchdog_on <= 1'b0;
    bus(1'b1, PC, 32'h03);
    wait_mode(1'b0, 1'b1);
    chk({o_core_clk_en, o_osc_en, o_addr_latch_strobe, o_prog_store_strobe}, 4'h0);
    chk({o_port0_float, o_port2_addr}, 2'h2);
    irq_req <= 1'b1;
    i_wdt_reset <= 1'b1;
    repeat (10) @(posedge i_clock);
    chk(o_in_stop, 1'b1);
    irq_req <= 1'b0;
    i_wdt_reset <= 1'b0;
    bus(1'b0, PC, 32'h0); chk(rd, 32'h03);
    i_nrst <= 1'b0;
    repeat (psm_pkg::IDLE_RESET_CLKS) @(posedge i_clock);
    i_nrst <= 1'b1;
    @(posedge i_clock);
    chk({o_in_stop, o_osc_en, o_core_clk_en}, 3'h3);
    bus(1'b0, PC, 32'h0); chk(rd, 32'(psm_pkg::PWR_CTRL_RESET));
    close_out();
  end
endmodule // tb
